/* File: hdl/rie_pkg.sv */
package rie_pkg;
	// =====================================================
	// widths
	localparam int PC_W   = 13;
	localparam int DATA_W = 8;
	// interrupt control register field: global enable position
	localparam int INT_EN_BIT = 7;
	// cycle counts
	localparam logic [1:0] RET_CYCLES = 2'h2;
	// reset values
	localparam logic [PC_W-1:0]   PC_RST  = 13'h0000;
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [DATA_W-1:0] ICR_RST = 8'h00;

	// decoded return operation
	typedef enum logic [1:0] {
		RIE_OP_NONE,
		RIE_OP_RET_INT,
		RIE_OP_RET_LIT,
		RIE_OP_RET_SUB
	} rie_op_t;

	// one decoded instruction from the decoder
	typedef struct packed {
		rie_op_t             op;
		logic [DATA_W-1:0]   literal;
	} rie_instr_t;
endpackage

/* File: hdl/rie_return_exec.sv */
// Overview of operation
// - return from interrupt pops the stack and loads its top into the pc.
// - return from interrupt sets global interrupt enable, bit 7 of control register.
// - return from interrupt takes two cycles and leaves status flags alone.
// - return with literal loads the 8-bit literal into the accumulator, flags untouched.
// - return with literal loads pc from stack top and pops that entry.
// - return with literal completes in two instruction cycles.
// - return from subroutine pops stack to pc, two cycles, flags untouched.
`timescale 1ns/1ps
module rie_return_exec (
	// clock and reset
	input  wire logic                        i_mclk,
	input  wire logic                        i_sys_rst,
	// instruction cycle enable and decoded instruction
	input  wire logic                        i_cyc_en,
	input  wire logic                        i_instr_vld,
	input  wire rie_pkg::rie_instr_t         i_instr,
	// return stack
	input  wire logic [rie_pkg::PC_W-1:0]    i_stack_top,
	output logic                             o_stack_pop,
	// core state
	input  wire logic [rie_pkg::DATA_W-1:0]  i_icr,
	output logic [rie_pkg::PC_W-1:0]         o_pc,
	output logic                             o_pc_load,
	output logic [rie_pkg::DATA_W-1:0]       o_acc,
	output logic                             o_acc_load,
	output logic [rie_pkg::DATA_W-1:0]       o_icr,
	output logic                             o_icr_load,
	output logic                             o_status_we,
	output logic                             o_flush,
	output logic                             o_busy
);
	// =====================================================
	// sequencer
	// a return takes two instruction cycles: the cycle of the take, which pops
	// the stack and loads the pc, and one bubble for the slot that was already
	// fetched from the old address. busy covers the bubble and ends at the next
	// instruction cycle enable, so a request arriving with that enable is lost;
	// the decoder must hold it and present it again at the following enable.
	// no counter: two cycles are fixed, so one state bit is all it needs
	typedef enum logic {RIE_IDLE, RIE_SECOND} rie_state_t;

	rie_state_t                  state_ff,   nxt_state;
	logic [rie_pkg::PC_W-1:0]    pc_ff,      nxt_pc;
	logic [rie_pkg::DATA_W-1:0]  acc_ff,     nxt_acc;
	logic [rie_pkg::DATA_W-1:0]  icr_ff,     nxt_icr;
	logic                        pop_ff,     nxt_pop;
	logic                        pcld_ff,    nxt_pcld;
	logic                        accld_ff,   nxt_accld;
	logic                        icrld_ff,   nxt_icrld;
	logic                        flush_ff,   nxt_flush;
	logic                        start;

	assign start = i_cyc_en && i_instr_vld && (state_ff == RIE_IDLE)
		&& (i_instr.op != rie_pkg::RIE_OP_NONE);

	// next values; strobes are single cycle
	always_comb begin
		nxt_state = state_ff;
		nxt_pc    = pc_ff;
		nxt_acc   = acc_ff;
		nxt_icr   = icr_ff;
		nxt_pop   = 1'b0;
		nxt_pcld  = 1'b0;
		nxt_accld = 1'b0;
		nxt_icrld = 1'b0;
		nxt_flush = 1'b0;
		unique case (state_ff)
			RIE_IDLE: begin
				if (start) begin
					// pop in first cycle so stack top is sampled once
					nxt_pop   = 1'b1;
					nxt_pc    = i_stack_top;
					nxt_pcld  = 1'b1;
					nxt_flush = 1'b1;
					nxt_state = RIE_SECOND;
					if (i_instr.op == rie_pkg::RIE_OP_RET_LIT) begin
						nxt_acc   = i_instr.literal;
						nxt_accld = 1'b1;
					end
					if (i_instr.op == rie_pkg::RIE_OP_RET_INT) begin
						nxt_icr          = i_icr;
						nxt_icr[rie_pkg::INT_EN_BIT] = 1'b1;
						nxt_icrld        = 1'b1;
					end
				end
			end
			RIE_SECOND: begin
				// second cycle executes the flushed slot as a bubble
				if (i_cyc_en) begin
					nxt_state = RIE_IDLE;
				end
			end
		endcase
	end

	// registers
	// reset clears every strobe so nothing fires as reset lets go
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_ff <= RIE_IDLE;
			pc_ff    <= rie_pkg::PC_RST;
			acc_ff   <= rie_pkg::ACC_RST;
			icr_ff   <= rie_pkg::ICR_RST;
			pop_ff   <= 1'b0;
			pcld_ff  <= 1'b0;
			accld_ff <= 1'b0;
			icrld_ff <= 1'b0;
			flush_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pc_ff    <= nxt_pc;
			acc_ff   <= nxt_acc;
			icr_ff   <= nxt_icr;
			pop_ff   <= nxt_pop;
			pcld_ff  <= nxt_pcld;
			accld_ff <= nxt_accld;
			icrld_ff <= nxt_icrld;
			flush_ff <= nxt_flush;
		end
	end

	// =====================================================
	// outputs
	// all data and strobes except o_status_we, tied low, leave flip-flops; busy is a decode of the state,
	// which is itself registered, so no input reaches an output in one cycle
	// and the stack, pc and accumulator see clean single-cycle strobes
	assign o_stack_pop = pop_ff;
	assign o_pc        = pc_ff;
	assign o_pc_load   = pcld_ff;
	assign o_acc       = acc_ff;
	assign o_acc_load  = accld_ff;
	assign o_icr       = icr_ff;
	assign o_icr_load  = icrld_ff;
	assign o_status_we = 1'b0;
	assign o_flush     = flush_ff;
	assign o_busy      = (state_ff == RIE_SECOND);

	// =====================================================
	// checks: stack and program counter
	// mask with only the enable bit set, so no check hard-codes its position
	logic [rie_pkg::DATA_W-1:0]  int_en_mask;

	always_comb begin
		int_en_mask                      = '0;
		int_en_mask[rie_pkg::INT_EN_BIT] = 1'b1;
	end

	// a take pops once and hands the stack top seen at the take to the pc
	a_pop_loads_pc: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		start |=> (o_stack_pop && o_pc_load && o_pc == $past(i_stack_top)))
		else $error("return did not pop stack into pc");

	a_pc_only_load: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$changed(o_pc) |-> o_pc_load)
		else $error("pc changed without a load strobe");

	a_strobe_needs_take: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!start |=> !(o_stack_pop || o_pc_load || o_flush))
		else $error("return strobe without an accepted return");

	// =====================================================
	// checks: accumulator
	a_lit_acc: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(start && i_instr.op == rie_pkg::RIE_OP_RET_LIT)
		|=> (o_acc_load && o_acc == $past(i_instr.literal)))
		else $error("literal not loaded into accumulator");

	a_lit_only_acc: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(start && i_instr.op != rie_pkg::RIE_OP_RET_LIT) |=> !o_acc_load)
		else $error("accumulator written by wrong return");

	// the other returns must leave the value a table lookup put there
	a_acc_held: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(start && i_instr.op != rie_pkg::RIE_OP_RET_LIT) |=> $stable(o_acc))
		else $error("accumulator changed by wrong return");

	// =====================================================
	// checks: interrupt control and status
	a_int_en_set: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(start && i_instr.op == rie_pkg::RIE_OP_RET_INT)
		|=> (o_icr_load && o_icr[rie_pkg::INT_EN_BIT]))
		else $error("interrupt return did not set enable");

	// only the enable bit may move; the other control bits pass through
	a_icr_bits_kept: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(start && i_instr.op == rie_pkg::RIE_OP_RET_INT)
		|=> (o_icr == ($past(i_icr) | int_en_mask)))
		else $error("interrupt return disturbed other control bits");

	a_icr_int_only: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(start && i_instr.op != rie_pkg::RIE_OP_RET_INT) |=> !o_icr_load)
		else $error("control register written by wrong return");

	a_flags_kept: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!o_status_we) else $error("status flags written");

	// =====================================================
	// checks: two-cycle sequencing and flush
	a_busy_after_take: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		start |=> o_busy)
		else $error("return did not enter its second cycle");

	a_busy_holds: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(o_busy && !i_cyc_en) |=> o_busy)
		else $error("second cycle ended without an enable");

	a_busy_ends: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(o_busy && i_cyc_en) |=> !o_busy)
		else $error("return ran past two instruction cycles");

	// a request in the bubble is dropped, not queued
	a_refused_busy: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(o_busy && i_cyc_en && i_instr_vld && i_instr.op != rie_pkg::RIE_OP_NONE)
		|=> !(o_stack_pop || o_pc_load))
		else $error("return accepted while busy");

	a_flush_pulse: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		start |=> (o_flush && o_busy) ##1 !o_flush)
		else $error("prefetch not flushed once");
endmodule // rie_return_exec

/* File: test/rie_return_exec_tb.sv */
`timescale 1ns/1ps
module rie_return_exec_tb;
	// =====================================================
	// stimulus and observed signals
	logic                           i_mclk = 1'b0;
	logic                           i_sys_rst = 1'b1;
	logic                           i_cyc_en = 1'b0;
	logic                           i_instr_vld = 1'b0;
	rie_pkg::rie_instr_t            i_instr = '0;
	logic [rie_pkg::PC_W-1:0]       i_stack_top = 13'h0000;
	logic [rie_pkg::DATA_W-1:0]     i_icr = 8'h00;
	logic                           o_stack_pop, o_pc_load, o_acc_load, o_icr_load;
	logic                           o_status_we, o_flush, o_busy;
	logic [rie_pkg::PC_W-1:0]       o_pc;
	logic [rie_pkg::DATA_W-1:0]     o_acc, o_icr;
	int                             n_fail = 0;
	int                             checked = 0;

	always #20 i_mclk = ~i_mclk;

	rie_return_exec rie_return_exec_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
		.i_cyc_en(i_cyc_en), .i_instr_vld(i_instr_vld), .i_instr(i_instr),
		.i_stack_top(i_stack_top), .o_stack_pop(o_stack_pop), .i_icr(i_icr), .o_pc(o_pc),
		.o_pc_load(o_pc_load), .o_acc(o_acc), .o_acc_load(o_acc_load), .o_icr(o_icr),
		.o_icr_load(o_icr_load), .o_status_we(o_status_we), .o_flush(o_flush), .o_busy(o_busy));

	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask

	// request held one edge; stack top and icr scrambled after take to catch late sampling
	task issue(input rie_pkg::rie_op_t op, input logic [7:0] lit, input logic [12:0] top,
		input logic [7:0] icr);
		@(posedge i_mclk);
		i_cyc_en <= 1'b1;
		i_instr_vld <= 1'b1;
		i_instr <= '{op, lit};
		i_stack_top <= top;
		i_icr <= icr;
		@(posedge i_mclk);
		i_cyc_en <= 1'b0;
		i_stack_top <= ~top;
		i_icr <= ~icr;
		#1;
		chk("pop", 1, o_stack_pop);
		chk("pc_load", 1, o_pc_load);
		chk("flush", 1, o_flush);
		chk("status_we", 0, o_status_we);
		chk("pc", top, o_pc);
	endtask

	// second cycle: strobes gone, busy holds, a request at the next enable is refused
	task end_ret;
		@(posedge i_mclk);
		#1;
		chk("pop_once", 0, o_stack_pop);
		chk("busy", 1, o_busy);
		@(posedge i_mclk);
		i_cyc_en <= 1'b1;
		i_instr <= '{rie_pkg::RIE_OP_RET_SUB, 8'h00};
		@(posedge i_mclk);
		i_cyc_en <= 1'b0;
		i_instr_vld <= 1'b0;
		#1;
		chk("busy_end", 0, o_busy);
		chk("refused", 0, o_stack_pop);
	endtask

	task t_ret_int;
		issue(rie_pkg::RIE_OP_RET_INT, 8'h3c, 13'h1abc, 8'h15);
		chk("icr", 8'h95, o_icr);
		chk("icr_load", 1, o_icr_load);
		chk("acc_load", 0, o_acc_load);
		end_ret();
	endtask

	task t_ret_lit;
		issue(rie_pkg::RIE_OP_RET_LIT, 8'hff, 13'h1fff, 8'h80);
		chk("acc", 8'hff, o_acc);
		chk("acc_load", 1, o_acc_load);
		chk("icr_load", 0, o_icr_load);
		chk("icr_kept", 8'h95, o_icr);
		end_ret();
	endtask

	task t_ret_sub;
		issue(rie_pkg::RIE_OP_RET_SUB, 8'h5a, 13'h0001, 8'h00);
		chk("acc_load", 0, o_acc_load);
		chk("icr_load", 0, o_icr_load);
		chk("acc_kept", 8'hff, o_acc);
		end_ret();
	endtask

	// non-return op, then a return without valid: neither may pop or stall
	task t_no_op;
		@(posedge i_mclk);
		i_cyc_en <= 1'b1;
		i_instr_vld <= 1'b1;
		i_instr <= '{rie_pkg::RIE_OP_NONE, 8'h77};
		@(posedge i_mclk);
		i_instr_vld <= 1'b0;
		i_instr <= '{rie_pkg::RIE_OP_RET_SUB, 8'h00};
		#1;
		chk("none_pop", 0, o_stack_pop);
		chk("none_flush", 0, o_flush);
		chk("none_busy", 0, o_busy);
		@(posedge i_mclk);
		i_cyc_en <= 1'b0;
		#1;
		chk("novld_pop", 0, o_stack_pop);
		chk("novld_busy", 0, o_busy);
	endtask

	// reset in the bubble: state and outputs back to reset values
	task t_reset_mid;
		issue(rie_pkg::RIE_OP_RET_LIT, 8'h42, 13'h0abc, 8'h00);
		@(posedge i_mclk);
		i_sys_rst <= 1'b1;
		#1;
		chk("rst_busy", 0, o_busy);
		chk("rst_pc", rie_pkg::PC_RST, o_pc);
		chk("rst_acc", rie_pkg::ACC_RST, o_acc);
		chk("rst_icr", rie_pkg::ICR_RST, o_icr);
		repeat (2) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
	endtask

	task close_out;
		$display("compares %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// watchdog: whole run needs well under a hundred cycles
	initial begin
		#80000;
		n_fail++;
		close_out();
	end

	initial begin
		repeat (10) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		t_ret_int();
		t_ret_lit();
		t_ret_sub();
		t_no_op();
		t_reset_mid();
		t_ret_int();
		close_out();
	end
endmodule // rie_return_exec_tb
